// file: scan_decode_asserts.sv
`default_nettype none

module scan_decode_asserts (
  input wire logic       SYS_CLK_I,
  input wire logic       SRST_I,
  input wire logic       TCK_I,
  input wire logic       TAP_RESET_I,
  input wire logic       TAP_CAPTURE_IR_I,
  input wire logic       TAP_SHIFT_IR_I,
  input wire logic       TAP_SHIFT_DR_I,
  input wire logic       TAP_UPDATE_IR_I,
  input wire logic       PIN_CHAIN_TDO_I,
  input wire logic       TDO_O,
  input wire logic       TDO_OE_O,
  input wire logic       PIN_CHAIN_SEL_O,
  input wire logic [2:0] PIN_CAPTURE_O,
  input wire logic       TEST_MODE_O,
  input wire logic       OUTPUTS_FLOAT_O,
  input wire logic [7:0] INPUT_IGNORE_O,
  input wire logic [2:0] OP_SELECT_O,
  input wire logic       RUN_OP_ACTIVE_O,
  input wire logic       TOGGLE_ACTIVE_O
);
  // ---------------------------------------------------------------
  // link side
  // ---------------------------------------------------------------
  a_oe_follows_shift: assert property (
    @(posedge TCK_I) disable iff (SRST_I)
    TDO_OE_O == (TAP_SHIFT_IR_I | TAP_SHIFT_DR_I))
    else $error("tdo enable does not follow shift state");
  a_ir_capture_hi: assert property (
    @(posedge TCK_I) disable iff (SRST_I)
    TAP_CAPTURE_IR_I ##1 TAP_SHIFT_IR_I |-> TDO_O)
    else $error("first instruction bit out is not one");
  a_ir_capture_lo: assert property (
    @(posedge TCK_I) disable iff (SRST_I)
    TAP_CAPTURE_IR_I ##1 TAP_SHIFT_IR_I [*2] |-> !TDO_O)
    else $error("second instruction bit out is not zero");
  a_pin_chain_mux: assert property (
    @(posedge TCK_I) disable iff (SRST_I)
    TAP_SHIFT_DR_I && PIN_CHAIN_SEL_O && $stable(PIN_CHAIN_TDO_I)
    |-> TDO_O == PIN_CHAIN_TDO_I)
    else $error("tdo does not carry the pin chain");
  a_sel_on_update: assert property (
    @(posedge TCK_I) disable iff (SRST_I)
    !$stable(PIN_CHAIN_SEL_O) |-> TAP_UPDATE_IR_I || TAP_RESET_I)
    else $error("chain select changed outside update");
  // ---------------------------------------------------------------
  // system side
  // ---------------------------------------------------------------
  a_float_excl: assert property (
    @(posedge SYS_CLK_I) disable iff (SRST_I)
    !(TEST_MODE_O && OUTPUTS_FLOAT_O))
    else $error("float and test mode both set");
  a_run_in_test: assert property (
    @(posedge SYS_CLK_I) disable iff (SRST_I)
    RUN_OP_ACTIVE_O |-> TEST_MODE_O && !TOGGLE_ACTIVE_O)
    else $error("run operation outside test mode");
  a_toggle_in_test: assert property (
    @(posedge SYS_CLK_I) disable iff (SRST_I)
    TOGGLE_ACTIVE_O |-> TEST_MODE_O)
    else $error("toggle outside test mode");
  a_reset_word: assert property (
    @(posedge SYS_CLK_I) disable iff (SRST_I)
    $fell(SRST_I) |-> OP_SELECT_O == 3'h2 && INPUT_IGNORE_O == 8'h00
    && !TEST_MODE_O && !RUN_OP_ACTIVE_O)
    else $error("control fields wrong after reset");
  a_tlr_word: assert property (
    @(posedge SYS_CLK_I) disable iff (SRST_I)
    $fell(TAP_RESET_I) |-> ##[0:6]
    (OP_SELECT_O == 3'h2 && INPUT_IGNORE_O == 8'h00))
    else $error("control fields wrong after logic reset");
  c_run: cover property (@(posedge SYS_CLK_I) $rose(RUN_OP_ACTIVE_O));
  c_toggle: cover property (@(posedge SYS_CLK_I) $rose(TOGGLE_ACTIVE_O));
  c_invert: cover property (@(posedge TCK_I)
    PIN_CHAIN_SEL_O && PIN_CAPTURE_O == 3'h4 && TAP_SHIFT_DR_I);
endmodule : scan_decode_asserts

bind scan_instruction_decode scan_decode_asserts chk (.SYS_CLK_I, .SRST_I,
  .TCK_I, .TAP_RESET_I, .TAP_CAPTURE_IR_I, .TAP_SHIFT_IR_I, .TAP_SHIFT_DR_I,
  .TAP_UPDATE_IR_I, .PIN_CHAIN_TDO_I, .TDO_O, .TDO_OE_O, .PIN_CHAIN_SEL_O,
  .PIN_CAPTURE_O, .TEST_MODE_O, .OUTPUTS_FLOAT_O, .INPUT_IGNORE_O,
  .OP_SELECT_O, .RUN_OP_ACTIVE_O, .TOGGLE_ACTIVE_O);

`default_nettype wire

// file: scan_decode_map.svh
`ifndef SCAN_DECODE_MAP_SVH
`define SCAN_DECODE_MAP_SVH

// -----------------------------------------------------------------
// test-control chain layout and reset value
// -----------------------------------------------------------------
`define CTRL_W          11
`define CTRL_RESET      11'h002
`define IGNORE_MSB      10
`define IGNORE_LSB      3
`define OPSEL_MSB       2
`define OPSEL_LSB       0

// -----------------------------------------------------------------
// instruction register
// -----------------------------------------------------------------
`define IR_W            8
`define IR_RESET        8'hFF
`define IR_CAPTURE      8'h81
`define BYPASS_CAPTURE  1'h0

// -----------------------------------------------------------------
// opcodes, bit 7 is the even-parity bit
// -----------------------------------------------------------------
`define OP_EXTEST_ALT                8'h00
`define OP_EXTEST                    8'h03
`define OP_SAMPLE                    8'h82
`define OP_BYPASS_A                  8'h84
`define OP_BYPASS_B                  8'h05
`define OP_BYPASS_C                  8'h88
`define OP_HIGHZ                     8'h06
`define OP_CLAMP                     8'h87
`define OP_RUN_TEST                  8'h09
`define OP_CHAIN_READ_NORMAL         8'h0A
`define OP_CHAIN_READ_TESTMODE       8'h8B
`define OP_CELL_SELF_CHECK           8'h0C
`define OP_OUTPUT_TOGGLE             8'h8D
`define OP_CONTROL_CHAIN_SCAN_NORMAL 8'h8E
`define OP_CONTROL_CHAIN_SCAN_TEST   8'h0F

// -----------------------------------------------------------------
// word handed to the system clock domain
// -----------------------------------------------------------------
`define CFG_W           13
`define CFG_RESET       13'h0002
`define LVL_W           2
`define LVL_RESET       2'h0

`endif

// file: scan_decode_pkg.sv
`default_nettype none

package scan_decode_pkg;

  // -----------------------------------------------------------------
  // selected data register
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    DR_BYPASS = 3'b001,
    DR_PIN    = 3'b010,
    DR_CTRL   = 3'b100
  } dr_sel_type;

  // -----------------------------------------------------------------
  // device operating mode
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_TEST   = 3'b010,
    MODE_FLOAT  = 3'b100
  } mode_type;

  // -----------------------------------------------------------------
  // pin-cell chain action in Capture-DR
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    CAP_SAMPLE = 3'b001,
    CAP_HOLD   = 3'b010,
    CAP_INVERT = 3'b100
  } capture_type;

endpackage : scan_decode_pkg

`default_nettype wire

// file: scan_instruction_decode.sv
// Function
// (R1) control chain is eleven bits between TDI/TDO
// (R2) capture leaves control chain unchanged
// (R3) reset control chain to 00000000010
// (R4) control chain shifts TDI into bit 10
// (R5) bits 10..3 ignore inputs, 2..0 op
// (R6) one-bit shortcut captures zero
// (R7) eight-bit instruction, even parity in bit 7
// (R8) opcode 03 selects pin chain, test mode
// (R9) boundary scan samples pins, cells drive
// (R10) 84, 05, 88 act as bypass
// (R11) unassigned codes act as bypass
// (R12) opcode 82 samples pins in normal mode
// (R13) opcode 06 floats outputs via shortcut
// (R14) opcode 87 holds cells on pins, test
// (R15) opcode 09 enables control-chain operations
// (R16) run operation during idle under run test
// (R17) chain reads keep pin chain in capture
// (R18) self check inverts pin cells in capture
// (R19) controller loads control chain before run
// (R20) remaining opcodes decode to their own entries
`include "scan_decode_map.svh"
`default_nettype none

module scan_instruction_decode (
  input  wire logic              SYS_CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              TCK_I,
  input  wire logic              TDI_I,
  input  wire logic              TAP_RESET_I,
  input  wire logic              TAP_IDLE_I,
  input  wire logic              TAP_CAPTURE_DR_I,
  input  wire logic              TAP_SHIFT_DR_I,
  input  wire logic              TAP_UPDATE_DR_I,
  input  wire logic              TAP_CAPTURE_IR_I,
  input  wire logic              TAP_SHIFT_IR_I,
  input  wire logic              TAP_UPDATE_IR_I,
  input  wire logic              PIN_CHAIN_TDO_I,
  output logic                   TDO_O,
  output logic                   TDO_OE_O,
  output logic                   PIN_CHAIN_SEL_O,
  output logic [2:0]             PIN_CAPTURE_O,
  output logic                   TEST_MODE_O,
  output logic                   OUTPUTS_FLOAT_O,
  output logic [7:0]             INPUT_IGNORE_O,
  output logic [2:0]             OP_SELECT_O,
  output logic                   RUN_OP_ACTIVE_O,
  output logic                   TOGGLE_ACTIVE_O
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic                          srst_meta_reg;
  logic                          srst_sync_reg;
  logic                          tck_rst;
  logic [`IR_W-1:0]              ir_shift_reg;
  logic                          shortcut_reg;
  logic [`CTRL_W-1:0]            ctrl_shift_reg;
  logic [`CTRL_W-1:0]            ctrl_shadow_reg;
  scan_decode_pkg::dr_sel_type   sel_reg;
  scan_decode_pkg::mode_type     mode_reg;
  scan_decode_pkg::capture_type  cap_reg;
  logic                          run_reg;
  logic                          toggle_reg;
  scan_decode_pkg::dr_sel_type   sel_next;
  scan_decode_pkg::mode_type     mode_next;
  scan_decode_pkg::capture_type  cap_next;
  logic                          run_next;
  logic                          toggle_next;
  logic                          cfg_toggle_reg;
  logic                          tdo_reg;
  logic                          tdo_oe_reg;
  logic                          tdo_next;
  logic                          run_lvl_reg;
  logic                          toggle_lvl_reg;
  logic                          pin_sel_reg;
  logic                          test_mode_tck;
  logic                          float_tck;
  logic [`CFG_W-1:0]             cfg_word;
  logic [`CFG_W-1:0]             cfg_sys;
  logic [`LVL_W-1:0]             lvl_sys;
  logic                          sel_ctrl;
  logic                          sel_bypass;

  // -----------------------------------------------------------------
  // power-up reset brought onto the link clock
  // -----------------------------------------------------------------
  always_ff @(posedge TCK_I) begin
    srst_meta_reg <= SRST_I;
    srst_sync_reg <= srst_meta_reg;
  end

  assign tck_rst    = srst_sync_reg | TAP_RESET_I;
  assign sel_ctrl   = (sel_reg == scan_decode_pkg::DR_CTRL);
  assign sel_bypass = (sel_reg == scan_decode_pkg::DR_BYPASS);

  // -----------------------------------------------------------------
  // instruction shift register
  // -----------------------------------------------------------------
  always_ff @(posedge TCK_I) begin
    if (tck_rst) begin
      ir_shift_reg <= `IR_RESET;
    end else if (TAP_CAPTURE_IR_I) begin
      ir_shift_reg <= `IR_CAPTURE;
    end else if (TAP_SHIFT_IR_I) begin
      ir_shift_reg <= {TDI_I, ir_shift_reg[`IR_W-1:1]}; // [R7]
    end
  end

  // -----------------------------------------------------------------
  // opcode decode; odd-parity codes fall through to bypass
  // -----------------------------------------------------------------
  always_comb begin
    sel_next    = scan_decode_pkg::DR_BYPASS;
    mode_next   = scan_decode_pkg::MODE_NORMAL;
    cap_next    = scan_decode_pkg::CAP_SAMPLE;
    run_next    = 1'b0;
    toggle_next = 1'b0;
    case (ir_shift_reg) // [R7] [R20]
      `OP_EXTEST_ALT,
      `OP_EXTEST: begin // [R8] [R9]
        sel_next  = scan_decode_pkg::DR_PIN;
        mode_next = scan_decode_pkg::MODE_TEST;
        cap_next  = scan_decode_pkg::CAP_SAMPLE;
      end
      `OP_SAMPLE: begin // [R12]
        sel_next  = scan_decode_pkg::DR_PIN;
        mode_next = scan_decode_pkg::MODE_NORMAL;
        cap_next  = scan_decode_pkg::CAP_SAMPLE;
      end
      `OP_BYPASS_A,
      `OP_BYPASS_B,
      `OP_BYPASS_C: begin // [R10]
        sel_next  = scan_decode_pkg::DR_BYPASS;
        mode_next = scan_decode_pkg::MODE_NORMAL;
      end
      `OP_HIGHZ: begin // [R13]
        sel_next  = scan_decode_pkg::DR_BYPASS;
        mode_next = scan_decode_pkg::MODE_FLOAT;
      end
      `OP_CLAMP: begin // [R14]
        sel_next  = scan_decode_pkg::DR_BYPASS;
        mode_next = scan_decode_pkg::MODE_TEST;
      end
      `OP_RUN_TEST: begin // [R15] [R16]
        sel_next  = scan_decode_pkg::DR_BYPASS;
        mode_next = scan_decode_pkg::MODE_TEST;
        run_next  = 1'b1;
      end
      `OP_CHAIN_READ_NORMAL: begin // [R17]
        sel_next  = scan_decode_pkg::DR_PIN;
        mode_next = scan_decode_pkg::MODE_NORMAL;
        cap_next  = scan_decode_pkg::CAP_HOLD;
      end
      `OP_CHAIN_READ_TESTMODE: begin // [R17]
        sel_next  = scan_decode_pkg::DR_PIN;
        mode_next = scan_decode_pkg::MODE_TEST;
        cap_next  = scan_decode_pkg::CAP_HOLD;
      end
      `OP_CELL_SELF_CHECK: begin // [R18]
        sel_next  = scan_decode_pkg::DR_PIN;
        mode_next = scan_decode_pkg::MODE_NORMAL;
        cap_next  = scan_decode_pkg::CAP_INVERT;
      end
      `OP_OUTPUT_TOGGLE: begin // [R20]
        sel_next    = scan_decode_pkg::DR_BYPASS;
        mode_next   = scan_decode_pkg::MODE_TEST;
        toggle_next = 1'b1;
      end
      `OP_CONTROL_CHAIN_SCAN_NORMAL: begin // [R20]
        sel_next  = scan_decode_pkg::DR_CTRL;
        mode_next = scan_decode_pkg::MODE_NORMAL;
      end
      `OP_CONTROL_CHAIN_SCAN_TEST: begin // [R20]
        sel_next  = scan_decode_pkg::DR_CTRL;
        mode_next = scan_decode_pkg::MODE_TEST;
      end
      default: begin // [R11]
        sel_next  = scan_decode_pkg::DR_BYPASS;
        mode_next = scan_decode_pkg::MODE_NORMAL;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // active instruction, updated on the falling edge in Update-IR
  // -----------------------------------------------------------------
  always_ff @(negedge TCK_I) begin
    if (tck_rst) begin
      sel_reg    <= scan_decode_pkg::DR_BYPASS;
      mode_reg   <= scan_decode_pkg::MODE_NORMAL;
      cap_reg    <= scan_decode_pkg::CAP_SAMPLE;
      run_reg    <= 1'b0;
      toggle_reg <= 1'b0;
      pin_sel_reg <= 1'b0;
    end else if (TAP_UPDATE_IR_I) begin
      sel_reg    <= sel_next;
      mode_reg   <= mode_next;
      cap_reg    <= cap_next;
      run_reg    <= run_next;
      toggle_reg <= toggle_next;
      pin_sel_reg <= (sel_next == scan_decode_pkg::DR_PIN); // [R8]
    end
  end

  // -----------------------------------------------------------------
  // one-bit shortcut register
  // -----------------------------------------------------------------
  always_ff @(posedge TCK_I) begin
    if (tck_rst) begin
      shortcut_reg <= `BYPASS_CAPTURE;
    end else if (TAP_CAPTURE_DR_I && sel_bypass) begin
      shortcut_reg <= `BYPASS_CAPTURE; // [R6] [R13] [R14] [R16]
    end else if (TAP_SHIFT_DR_I && sel_bypass) begin
      shortcut_reg <= TDI_I; // [R6]
    end
  end

  // -----------------------------------------------------------------
  // test-control chain: shift stage
  // -----------------------------------------------------------------
  always_ff @(posedge TCK_I) begin
    if (tck_rst) begin
      ctrl_shift_reg <= `CTRL_RESET; // [R3]
    end else if (TAP_SHIFT_DR_I && sel_ctrl) begin
      ctrl_shift_reg <= {TDI_I, ctrl_shift_reg[`CTRL_W-1:1]}; // [R1] [R4]
    end
    // capture with this chain selected leaves the stage alone [R2]
  end

  // -----------------------------------------------------------------
  // test-control chain: shadow, loaded on the falling edge
  // -----------------------------------------------------------------
  always_ff @(negedge TCK_I) begin
    if (tck_rst) begin
      ctrl_shadow_reg <= `CTRL_RESET; // [R3]
    end else if (TAP_UPDATE_DR_I && sel_ctrl) begin
      ctrl_shadow_reg <= ctrl_shift_reg; // [R1] [R19]
    end
  end

  // -----------------------------------------------------------------
  // change marker for the system-side copy
  // -----------------------------------------------------------------
  always_ff @(negedge TCK_I) begin
    if (srst_sync_reg) begin
      cfg_toggle_reg <= 1'b0;
    end else if (TAP_RESET_I || TAP_UPDATE_IR_I ||
                 (TAP_UPDATE_DR_I && sel_ctrl)) begin
      cfg_toggle_reg <= ~cfg_toggle_reg;
    end
  end

  // -----------------------------------------------------------------
  // serial output, changes on the falling edge
  // -----------------------------------------------------------------
  always_comb begin
    tdo_next = ir_shift_reg[0];
    if (!TAP_SHIFT_IR_I) begin
      unique case (sel_reg)
        scan_decode_pkg::DR_BYPASS: tdo_next = shortcut_reg;
        scan_decode_pkg::DR_PIN:    tdo_next = PIN_CHAIN_TDO_I;
        scan_decode_pkg::DR_CTRL:   tdo_next = ctrl_shift_reg[0]; // [R4]
      endcase
    end
  end

  always_ff @(negedge TCK_I) begin
    if (tck_rst) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= TAP_SHIFT_IR_I | TAP_SHIFT_DR_I;
    end
  end

  // -----------------------------------------------------------------
  // idle-time activity levels
  // -----------------------------------------------------------------
  always_ff @(posedge TCK_I) begin
    if (tck_rst) begin
      run_lvl_reg <= 1'b0;
    end else begin
      run_lvl_reg <= run_reg & TAP_IDLE_I; // [R15] [R16]
    end
  end

  always_ff @(posedge TCK_I) begin
    if (tck_rst) begin
      toggle_lvl_reg <= 1'b0;
    end else begin
      toggle_lvl_reg <= toggle_reg & TAP_IDLE_I; // [R20]
    end
  end

  // -----------------------------------------------------------------
  // mode flags of the active instruction
  // -----------------------------------------------------------------
  assign test_mode_tck = (mode_reg == scan_decode_pkg::MODE_TEST);
  assign float_tck     = (mode_reg == scan_decode_pkg::MODE_FLOAT);

  // -----------------------------------------------------------------
  // crossing into the system clock domain
  // -----------------------------------------------------------------
  assign cfg_word = {
    test_mode_tck,                                 // [R9] [R14]
    float_tck,                                     // [R13]
    ctrl_shadow_reg[`IGNORE_MSB:`IGNORE_LSB],      // [R5]
    ctrl_shadow_reg[`OPSEL_MSB:`OPSEL_LSB]         // [R5]
  };

  word_cross #(
    .WORD_W     (`CFG_W),
    .LVL_W      (`LVL_W),
    .WORD_RESET (`CFG_RESET),
    .LVL_RESET  (`LVL_RESET)
  ) u_cross (
    .clk_i        (SYS_CLK_I),
    .rst_i        (SRST_I),
    .src_word_i   (cfg_word),
    .src_toggle_i (cfg_toggle_reg),
    .src_lvl_i    ({run_lvl_reg, toggle_lvl_reg}),
    .word_o       (cfg_sys),
    .lvl_o        (lvl_sys)
  );

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign TDO_O           = tdo_reg;
  assign TDO_OE_O        = tdo_oe_reg;
  assign PIN_CHAIN_SEL_O = pin_sel_reg;
  assign PIN_CAPTURE_O   = cap_reg;
  assign TEST_MODE_O     = cfg_sys[12];
  assign OUTPUTS_FLOAT_O = cfg_sys[11];
  assign INPUT_IGNORE_O  = cfg_sys[10:3];
  assign OP_SELECT_O     = cfg_sys[2:0];
  assign RUN_OP_ACTIVE_O = lvl_sys[1];
  assign TOGGLE_ACTIVE_O = lvl_sys[0];

endmodule : scan_instruction_decode

`default_nettype wire

// file: tap_host.sv
`default_nettype none

module tap_host (
  output logic       tck_o,
  output logic       tdi_o,
  output logic [7:0] st_o,
  input  wire logic  tdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // st_o: reset, idle, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir
  logic tdo_seen;

  initial begin
    tck_o = 1'h1;
    tdi_o = 1'h0;
    st_o  = 8'h01;
  end

  // tck rests high between frames; state moves just after each rise
  task automatic step(input logic [7:0] st, input logic d);
    #1 st_o = st;
    tdi_o = (st[3] | st[6]) ? d : ~tdi_o;
    #14 tck_o = 1'h0;
    #14 tdo_seen = tdo_i;
    #1 tck_o = 1'h1;
  endtask : step

  task automatic tap_reset();
    repeat (5) step(8'h01, 1'h0);
    step(8'h02, 1'h0);
  endtask : tap_reset

  // codes go out as given, parity bit included; the task computes no parity
  task automatic ir_scan(input logic [7:0] op, output logic [7:0] q);
    step(8'h00, 1'h0);
    step(8'h20, 1'h0);
    for (int i = 0; i < 8; i++) begin
      step(8'h40, op[i]);
      q[i] = tdo_seen;
    end
    step(8'h00, 1'h0);
    step(8'h80, 1'h0);
    step(8'h02, 1'h0);
  endtask : ir_scan

  task automatic dr_scan(input int n, input logic [10:0] d,
                         output logic [10:0] q);
    q = 11'h000;
    step(8'h00, 1'h0);
    step(8'h04, 1'h0);
    for (int i = 0; i < n; i++) begin
      step(8'h08, d[i]);
      q[i] = tdo_seen;
    end
    step(8'h00, 1'h0);
    step(8'h10, 1'h0);
    step(8'h02, 1'h0);
  endtask : dr_scan
endmodule : tap_host

`default_nettype wire

// file: tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk, srst, pin_tdo, tck, tdi, tdo;
  logic        pin_sel, test_mode, flt, run_act, tog_act;
  logic [7:0]  st, ignore, iq, op;
  logic [2:0]  pin_cap, op_sel;
  logic [10:0] ctrl, d, q, x, g;
  int          err_total, num_checks;
  logic [7:0]  ops [16] = '{8'h8E, 8'h0F, 8'h00, 8'h03, 8'h82, 8'h84,
    8'h05, 8'h88, 8'h06, 8'h87, 8'h09, 8'h0A, 8'h8B, 8'h0C, 8'h8D, 8'hFF};

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  scan_instruction_decode uut (.SYS_CLK_I(sys_clk), .SRST_I(srst),
    .TCK_I(tck), .TDI_I(tdi), .TAP_RESET_I(st[0]), .TAP_IDLE_I(st[1]),
    .TAP_CAPTURE_DR_I(st[2]), .TAP_SHIFT_DR_I(st[3]),
    .TAP_UPDATE_DR_I(st[4]), .TAP_CAPTURE_IR_I(st[5]),
    .TAP_SHIFT_IR_I(st[6]), .TAP_UPDATE_IR_I(st[7]),
    .PIN_CHAIN_TDO_I(pin_tdo), .TDO_O(tdo), .TDO_OE_O(),
    .PIN_CHAIN_SEL_O(pin_sel), .PIN_CAPTURE_O(pin_cap),
    .TEST_MODE_O(test_mode), .OUTPUTS_FLOAT_O(flt),
    .INPUT_IGNORE_O(ignore), .OP_SELECT_O(op_sel),
    .RUN_OP_ACTIVE_O(run_act), .TOGGLE_ACTIVE_O(tog_act));

  tap_host host (.tck_o(tck), .tdi_o(tdi), .st_o(st), .tdo_i(tdo));

  task automatic cmp(input string what, input logic [10:0] exp,
                     input logic [10:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // {register 0 bypass 1 pins 2 control, test, float, capture}
  function automatic logic [6:0] expect_op(input logic [7:0] c);
    case (c)
      8'h00, 8'h03:        return 7'h31;
      8'h82:               return 7'h21;
      8'h06:               return 7'h09;
      8'h87, 8'h09, 8'h8D: return 7'h11;
      8'h0A:               return 7'h22;
      8'h8B:               return 7'h32;
      8'h0C:               return 7'h24;
      8'h8E:               return 7'h41;
      8'h0F:               return 7'h51;
      default:             return 7'h01;
    endcase
  endfunction : expect_op

  task automatic try_op(input logic [7:0] c);
    logic [6:0] e;
    e = expect_op(c);
    d = 11'($urandom);
    @(posedge sys_clk);
    #1 pin_tdo = 1'($urandom);
    host.ir_scan(c, iq);
    cmp("ir capture", 11'h081, {3'h0, iq});
    repeat (8) @(posedge sys_clk);
    x = {6'h00, e[6:5] == 2'h1, e[4:3], c == 8'h09, c == 8'h8D};
    g = {6'h00, pin_sel, test_mode, flt, run_act, tog_act};
    cmp("mode", x, g);
    x = {8'h00, e[2:0]};
    if (e[6:5] == 2'h1) cmp("capture", x, {8'h00, pin_cap});
    host.dr_scan(3, d, q);
    case (e[6:5])
      2'h1:    x = {8'h00, {3{pin_tdo}}};
      2'h2:    x = {8'h00, ctrl[2:0]};
      default: x = {8'h00, d[1:0], 1'h0};
    endcase
    cmp("scan out", x, q);
    if (e[6:5] == 2'h2) ctrl = {d[2:0], ctrl[10:3]};
    repeat (8) @(posedge sys_clk);
    cmp("fields", ctrl, {ignore, op_sel});
  endtask : try_op

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  initial begin
    err_total = 0;
    num_checks = 0;
    srst = 1'h1;
    pin_tdo = 1'h0;
    ctrl = 11'h002;
    void'($urandom(43529));
    fork
      host.tap_reset();
      begin
        repeat (20) @(posedge sys_clk);
        #1 srst = 1'h0;
      end
    join
    repeat (8) @(posedge sys_clk);
    cmp("reset fields", ctrl, {ignore, op_sel});
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      d = 11'($urandom);
      host.ir_scan(8'h8E, iq);
      host.dr_scan(11, d, q);
      cmp("chain out", ctrl, q);
      ctrl = d;
      repeat (8) @(posedge sys_clk);
      cmp("chain fields", ctrl, {ignore, op_sel});
    end
    $display("test control chain done");
    foreach (ops[i]) try_op(ops[i]);
    $display("test opcode table done");
    for (int k = 0; k < 10; k++) begin
      op = 8'($urandom);
      if (k[0]) op[7] = ^op[6:0];
      try_op(op);
    end
    $display("test random codes done");
    host.ir_scan(8'h09, iq);
    // idle reaches logic reset only through the two select states
    repeat (2) host.step(8'h00, 1'h0);
    host.tap_reset();
    ctrl = 11'h002;
    repeat (8) @(posedge sys_clk);
    cmp("logic reset fields", ctrl, {ignore, op_sel});
    cmp("logic reset mode", 11'h000, {9'h000, test_mode, run_act});
    $display("test logic reset done");
    end_of_test();
  end

  initial begin
    #300us;
    err_total++;
    end_of_test();
  end
endmodule : tb

`default_nettype wire

// file: word_cross.sv
`default_nettype none

module word_cross #(
  parameter int                WORD_W     = 13,
  parameter int                LVL_W      = 2,
  parameter logic [WORD_W-1:0] WORD_RESET = '0,
  parameter logic [LVL_W-1:0]  LVL_RESET  = '0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [WORD_W-1:0] src_word_i,
  input  wire logic              src_toggle_i,
  input  wire logic [LVL_W-1:0]  src_lvl_i,
  output logic      [WORD_W-1:0] word_o,
  output logic      [LVL_W-1:0]  lvl_o
);

  logic              tog_meta_reg;
  logic              tog_sync_reg;
  logic              tog_seen_reg;
  logic [LVL_W-1:0]  lvl_meta_reg;
  logic [WORD_W-1:0] word_reg;
  logic [LVL_W-1:0]  lvl_reg;

  // -----------------------------------------------------------------
  // toggle handshake: the source word stays put for many link cycles
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
    end else begin
      tog_meta_reg <= src_toggle_i;
      tog_sync_reg <= tog_meta_reg;
      tog_seen_reg <= tog_sync_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg <= WORD_RESET;
    end else if (tog_sync_reg != tog_seen_reg) begin
      word_reg <= src_word_i;
    end
  end

  // -----------------------------------------------------------------
  // plain two-flop level synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_meta_reg <= LVL_RESET;
      lvl_reg      <= LVL_RESET;
    end else begin
      lvl_meta_reg <= src_lvl_i;
      lvl_reg      <= lvl_meta_reg;
    end
  end

  assign word_o = word_reg;
  assign lvl_o  = lvl_reg;

endmodule : word_cross

`default_nettype wire
